// >>> sigmod_defs.svh
// What this block does
// (RULE1) host disarms, resets gating, reads/shifts four nibbles
// (RULE2) host packs signature into low 16 bits
// (RULE3) nibbles shifted out are lost for good
// (RULE4) result read ends running acquisition first
// (RULE5) host reads six event nibbles into 24 bits
// (RULE6) host reads 16 waveform nibbles, splits high/low; sigmod_host keeps all 64 bits in one word, no split
// (RULE7) host reads signature, events, then waveform
// (RULE8) waveform travels through event and signature stages
// (RULE9) opcode 80 drives status plus data byte
// (RULE10) status peek never shifts nor disturbs acquisition
// (RULE11) byte bits 0-3 are output nibble
// (RULE12) bit 4 means clock edge within 200 ms
// (RULE13) bit 5 start seen, bit 6 stop seen
// (RULE14) bit 7 means clock module grounded
// (RULE15) host sends each opcode as one byte
// (RULE16) host idles 200 ms before opcode 00
// (RULE17) early opcode 00 ignored, stay detached
// (RULE18) 00 attaches, F0 detaches, pod then ignores
// (RULE19) single chain, four bits by 26 stages
// (RULE20) opcode 90 shifts every stage one nibble
// (RULE21) 28 disarms, 29 arms start handling
// (RULE22) opcode 80 announces a read response
// (RULE23) response held until next opcode, no stray shifts
`ifndef SIGMOD_DEFS_SVH
`define SIGMOD_DEFS_SVH

`define SM_STAGES 26
`define SM_SIG_FIRST 0
`define SM_SIG_LAST 3
`define SM_EVT_FIRST 4
`define SM_EVT_LAST 9
`define SM_WAV_FIRST 10
`define SM_WAV_LAST 25

`define SM_OP_ATTACH 8'h00
`define SM_OP_DISARM 8'h28
`define SM_OP_ARM 8'h29
`define SM_OP_READ 8'h80
`define SM_OP_SHIFT 8'h90
`define SM_OP_CLR_SIG 8'hb0
`define SM_OP_CLR_EVT 8'hc0
`define SM_OP_CLR_WAV 8'hd0
`define SM_OP_CLR_GATE 8'he0
`define SM_OP_DETACH 8'hf0

`define SM_BIT_CLK_SEEN 4
`define SM_BIT_START 5
`define SM_BIT_STOP 6
`define SM_BIT_GROUND 7

`define SM_CLK_NS 8
`define SM_WINDOW_MS 200
`define SM_WINDOW_CYC ((`SM_WINDOW_MS * 1000000) / `SM_CLK_NS)
`define SM_CNT_W 25

`define SM_REG_CTRL 32'h0000_0000
`define SM_REG_STATUS 32'h0000_0004
`define SM_CTRL_RESET 32'h0000_0001
`define SM_CTRL_LISTEN 0
`define SM_ST_ATTACHED 0
`define SM_ST_ARMED 1
`define SM_ST_RUN 2
`define SM_ST_START 3
`define SM_ST_STOP 4
`define SM_ST_CLK_SEEN 5
`define SM_ST_NIB_LSB 8
`define SM_RESP_OKAY 2'b00
`define SM_RESP_SLVERR 2'b10

`endif

// >>> sigmod_pkg.sv
package sigmod_pkg;
    typedef logic [3:0] sigmod_nib_t;
    typedef logic [7:0] sigmod_byte_t;
    typedef enum logic [1:0] {
        ACQ_WAIT,
        ACQ_RUN,
        ACQ_DONE
    } sigmod_acq_t;
endpackage : sigmod_pkg

// >>> sigmod_axi.sv
`timescale 1ns/1ps
`include "sigmod_defs.svh"
module sigmod_axi (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [31:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [31:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic [31:0] status_in,
    output logic [31:0] ctrl_out
);
    import sigmod_pkg::*;

    logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [31:0] next_ctrl;
    logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    integer i;

    always_comb begin
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_ctrl = ctrl_out;
        next_bvalid = bvalid_out;
        next_bresp = bresp_out;
        next_rvalid = rvalid_out;
        next_rresp = rresp_out;
        next_rdata = rdata_out;
        if (awvalid_in && awready_out) begin
            next_aw_got = 1'b1;
            next_aw_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_w_got = 1'b1;
            next_w_data = wdata_in;
            next_w_strb = wstrb_in;
        end
        if (bvalid_out && bready_in) begin
            next_bvalid = 1'b0;
        end
        // response only once both halves are held
        if (aw_got && w_got && !bvalid_out) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `SM_RESP_SLVERR;
            if (aw_addr[31:2] == 30'(`SM_REG_CTRL >> 2)) begin
                next_bresp = `SM_RESP_OKAY;
                for (i = 0; i < 4; i = i + 1) begin
                    if (w_strb[i]) begin
                        next_ctrl[i*8 +: 8] = w_data[i*8 +: 8];
                    end
                end
            end else if (aw_addr[31:2] == 30'(`SM_REG_STATUS >> 2)) begin
                next_bresp = `SM_RESP_OKAY;
            end
        end
        if (rvalid_out && rready_in) begin
            next_rvalid = 1'b0;
        end
        if (arvalid_in && arready_out) begin
            next_rvalid = 1'b1;
            next_rresp = `SM_RESP_OKAY;
            if (araddr_in[31:2] == 30'(`SM_REG_CTRL >> 2)) begin
                next_rdata = ctrl_out;
            end else if (araddr_in[31:2] == 30'(`SM_REG_STATUS >> 2)) begin
                next_rdata = status_in;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = `SM_RESP_SLVERR;
            end
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            ctrl_out <= `SM_CTRL_RESET;
            bvalid_out <= 1'b0;
            bresp_out <= `SM_RESP_OKAY;
            rvalid_out <= 1'b0;
            rresp_out <= `SM_RESP_OKAY;
            rdata_out <= 32'h0000_0000;
            awready_out <= 1'b0;
            wready_out <= 1'b0;
            arready_out <= 1'b0;
        end else begin
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            ctrl_out <= next_ctrl;
            bvalid_out <= next_bvalid;
            bresp_out <= next_bresp;
            rvalid_out <= next_rvalid;
            rresp_out <= next_rresp;
            rdata_out <= next_rdata;
            awready_out <= next_awready;
            wready_out <= next_wready;
            arready_out <= next_arready;
        end
    end
endmodule : sigmod_axi

// >>> sigmod_top.sv
`timescale 1ns/1ps
`include "sigmod_defs.svh"
module sigmod_top #(
    parameter int unsigned WINDOW_CYC = `SM_WINDOW_CYC
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    // pod bus, opcode side
    input wire logic pod_wr_in,
    input wire sigmod_pkg::sigmod_byte_t pod_op_in,
    // pod bus, response side
    output sigmod_pkg::sigmod_byte_t pod_data_out,
    output logic pod_oe_out,
    output logic pod_attached_out,
    // acquisition side
    input wire logic start_edge_in,
    input wire logic stop_edge_in,
    input wire logic clk_edge_in,
    input wire logic grounded_in,
    input wire logic result_load_in,
    input wire logic [103:0] result_data_in,
    output logic acq_run_out,
    output logic acq_end_out,
    // register bus
    input wire logic [31:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [31:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in
);
    import sigmod_pkg::*;

    localparam logic [`SM_CNT_W-1:0] WIN = `SM_CNT_W'(WINDOW_CYC);

    function automatic logic is_op(input sigmod_byte_t op, input sigmod_byte_t code);
        is_op = (op == code);
    endfunction : is_op

    logic [31:0] ctrl, status;
    logic listen;
    logic op_seen;
    sigmod_byte_t op;

    sigmod_nib_t chain [`SM_STAGES];
    sigmod_nib_t next_chain [`SM_STAGES];
    sigmod_acq_t acq, next_acq;
    logic armed, next_armed;
    logic started, next_started;
    logic stopped, next_stopped;
    logic attached, next_attached;
    logic [`SM_CNT_W-1:0] idle_cnt, next_idle_cnt;
    logic [`SM_CNT_W-1:0] clk_cnt, next_clk_cnt;
    logic clk_seen;
    sigmod_byte_t next_pod_data;
    logic next_pod_oe, next_acq_end;
    logic do_shift, do_clr_sig, do_clr_evt, do_clr_wav;

    sigmod_axi u_axi (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in),
        .awready_out(awready_out),
        .wdata_in(wdata_in),
        .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in),
        .wready_out(wready_out),
        .bresp_out(bresp_out),
        .bvalid_out(bvalid_out),
        .bready_in(bready_in),
        .araddr_in(araddr_in),
        .arvalid_in(arvalid_in),
        .arready_out(arready_out),
        .rdata_out(rdata_out),
        .rresp_out(rresp_out),
        .rvalid_out(rvalid_out),
        .rready_in(rready_in),
        .status_in(status),
        .ctrl_out(ctrl)
    );

    // software can mute the pod bus listener entirely
    assign listen = ctrl[`SM_CTRL_LISTEN];
    assign op = pod_op_in;
    // while detached only the attach opcode is heard
    assign op_seen = pod_wr_in && listen && (attached || is_op(op, `SM_OP_ATTACH));
    assign clk_seen = (clk_cnt < WIN); // RULE12

    assign do_shift = op_seen && is_op(op, `SM_OP_SHIFT); // RULE23
    assign do_clr_sig = op_seen && is_op(op, `SM_OP_CLR_SIG);
    assign do_clr_evt = op_seen && is_op(op, `SM_OP_CLR_EVT);
    assign do_clr_wav = op_seen && is_op(op, `SM_OP_CLR_WAV);

    assign status = {
        16'h0000,
        4'h0,
        chain[0],
        2'b00,
        clk_seen,
        stopped,
        started,
        (acq == ACQ_RUN),
        armed,
        attached
    };

    // result chain, stage 0 is the output end
    genvar g;
    generate
        for (g = 0; g < `SM_STAGES; g = g + 1) begin : g_stage
            always_comb begin
                next_chain[g] = chain[g];
                if (result_load_in) begin
                    next_chain[g] = result_data_in[g*4 +: 4];
                end else if (do_shift) begin
                    // top stage refills with zero, shifted data is gone
                    if (g == `SM_STAGES - 1) begin
                        next_chain[g] = 4'h0; // RULE3
                    end else begin
                        // wrapped index keeps the unused top-stage branch in range
                        next_chain[g] = chain[(g + 1) % `SM_STAGES]; // RULE8 RULE19 RULE20
                    end
                end else if (do_clr_sig && g <= `SM_SIG_LAST) begin
                    next_chain[g] = 4'h0;
                end else if (do_clr_evt && g >= `SM_EVT_FIRST && g <= `SM_EVT_LAST) begin
                    next_chain[g] = 4'h0;
                end else if (do_clr_wav && g >= `SM_WAV_FIRST) begin
                    next_chain[g] = 4'h0;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    chain[g] <= 4'h0;
                end else begin
                    chain[g] <= next_chain[g];
                end
            end
        end
    endgenerate

    // gating, attachment and response byte
    always_comb begin
        next_acq = acq;
        next_armed = armed;
        next_started = started;
        next_stopped = stopped;
        next_attached = attached;
        next_pod_data = pod_data_out;
        next_pod_oe = pod_oe_out;
        next_acq_end = 1'b0;
        next_idle_cnt = idle_cnt;
        next_clk_cnt = clk_cnt;

        // any bus write restarts the idle measure
        if (pod_wr_in) begin
            next_idle_cnt = '0;
        end else if (idle_cnt < WIN) begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
        if (clk_edge_in) begin
            next_clk_cnt = '0;
        end else if (clk_cnt < WIN) begin
            next_clk_cnt = clk_cnt + 1'b1;
        end

        case (acq)
            ACQ_WAIT: begin
                if (armed && start_edge_in) begin
                    next_acq = ACQ_RUN;
                    next_started = 1'b1;
                end
            end
            ACQ_RUN: begin
                if (stop_edge_in) begin
                    next_acq = ACQ_DONE;
                    next_stopped = 1'b1;
                end
            end
            ACQ_DONE: begin
                next_acq = ACQ_DONE;
            end
            default: begin
                next_acq = ACQ_WAIT;
            end
        endcase

        // response stays up until the next opcode arrives
        if (op_seen) begin
            next_pod_oe = 1'b0; // RULE23
            case (op)
                `SM_OP_ATTACH: begin
                    if (idle_cnt >= WIN) begin
                        next_attached = 1'b1; // RULE18
                    end // RULE17
                end
                `SM_OP_DETACH: begin
                    next_attached = 1'b0; // RULE18
                end
                `SM_OP_DISARM: begin
                    next_armed = 1'b0; // RULE21
                end
                `SM_OP_ARM: begin
                    next_armed = 1'b1; // RULE21
                end
                `SM_OP_CLR_GATE: begin
                    next_acq = ACQ_WAIT;
                    next_started = 1'b0;
                    next_stopped = 1'b0;
                end
                `SM_OP_READ: begin
                    // disarmed read is a result read; armed read is a peek
                    if (!armed && acq == ACQ_RUN) begin
                        next_acq = ACQ_DONE; // RULE4
                        next_acq_end = 1'b1; // RULE4
                    end // RULE10
                    next_pod_oe = 1'b1; // RULE9 RULE22
                    next_pod_data[3:0] = chain[0]; // RULE11
                    next_pod_data[`SM_BIT_CLK_SEEN] = clk_seen; // RULE12
                    next_pod_data[`SM_BIT_START] = started || next_started; // RULE13
                    next_pod_data[`SM_BIT_STOP] = stopped || next_stopped; // RULE13
                    next_pod_data[`SM_BIT_GROUND] = grounded_in; // RULE14
                end
                default: begin
                    next_attached = attached;
                end
            endcase
        end
        if (!listen) begin
            next_pod_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            acq <= ACQ_WAIT;
            armed <= 1'b0;
            started <= 1'b0;
            stopped <= 1'b0;
            attached <= 1'b0;
            pod_data_out <= 8'h00;
            pod_oe_out <= 1'b0;
            acq_end_out <= 1'b0;
            idle_cnt <= '0;
            clk_cnt <= WIN;
            pod_attached_out <= 1'b0;
            acq_run_out <= 1'b0;
        end else begin
            acq <= next_acq;
            armed <= next_armed;
            started <= next_started;
            stopped <= next_stopped;
            attached <= next_attached;
            pod_data_out <= next_pod_data;
            pod_oe_out <= next_pod_oe;
            acq_end_out <= next_acq_end;
            idle_cnt <= next_idle_cnt;
            clk_cnt <= next_clk_cnt;
            pod_attached_out <= next_attached;
            acq_run_out <= (next_acq == ACQ_RUN);
        end
    end
endmodule : sigmod_top

// >>> sigmod_top_properties.sv
`timescale 1ns/1ps
`include "sigmod_defs.svh"
module sigmod_top_properties #(
    parameter int unsigned WINDOW_CYC = 50
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic pod_wr_in,
    input wire sigmod_pkg::sigmod_byte_t pod_op_in,
    input wire sigmod_pkg::sigmod_byte_t pod_data_out,
    input wire logic pod_oe_out,
    input wire logic pod_attached_out,
    input wire logic start_edge_in,
    input wire logic clk_edge_in,
    input wire logic grounded_in,
    input wire logic acq_run_out,
    input wire logic acq_end_out
);
    import sigmod_pkg::*;
    int unsigned idle_cnt;
    int unsigned next_idle_cnt;
    int unsigned clk_age;
    int unsigned next_clk_age;
    logic rd_go;
    assign rd_go = pod_wr_in && pod_op_in == `SM_OP_READ && pod_attached_out;
    // both counters saturate two past the window so the bound is never ambiguous
    always_comb begin
        next_idle_cnt = idle_cnt;
        next_clk_age = clk_age;
        if (pod_wr_in)
            next_idle_cnt = 0;
        else if (idle_cnt <= WINDOW_CYC + 1)
            next_idle_cnt = idle_cnt + 1;
        if (clk_edge_in)
            next_clk_age = 0;
        else if (clk_age <= WINDOW_CYC + 1)
            next_clk_age = clk_age + 1;
    end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            idle_cnt <= 0;
            clk_age <= WINDOW_CYC + 2;
        end else begin
            idle_cnt <= next_idle_cnt;
            clk_age <= next_clk_age;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_READ_OE: assert property (rd_go |=> pod_oe_out)
        else $error("read opcode gave no response");
    AST_GROUND: assert property (rd_go |=> pod_data_out[7] == $past(grounded_in))
        else $error("ground bit wrong");
    // a running period implies a start edge was taken
    AST_START: assert property (rd_go && acq_run_out |=> pod_data_out[5])
        else $error("start bit missing");
    AST_CLK_NEW: assert property (rd_go && clk_age < WINDOW_CYC |=> pod_data_out[4])
        else $error("clock seen bit missing");
    AST_CLK_OLD: assert property (rd_go && !clk_edge_in && clk_age == WINDOW_CYC + 2
        |=> !pod_data_out[4]) else $error("clock seen bit stale");
    AST_HOLD: assert property (pod_oe_out && !pod_wr_in |=> pod_oe_out && $stable(pod_data_out))
        else $error("response byte not held");
    AST_SHIFT_DROP: assert property (pod_oe_out && pod_attached_out && pod_wr_in
        && pod_op_in == `SM_OP_SHIFT |=> !pod_oe_out) else $error("response kept after shift");
    AST_EARLY: assert property (pod_wr_in && pod_op_in == `SM_OP_ATTACH && !pod_attached_out
        && idle_cnt + 2 < WINDOW_CYC |=> !pod_attached_out) else $error("early attach taken");
    AST_ATTACH: assert property (pod_wr_in && pod_op_in == `SM_OP_ATTACH
        && idle_cnt == WINDOW_CYC + 2 |=> pod_attached_out) else $error("attach refused");
    AST_DETACH: assert property (pod_wr_in && pod_op_in == `SM_OP_DETACH && pod_attached_out
        |=> !pod_attached_out) else $error("detach ignored");
    AST_END: assert property ($rose(acq_end_out) |-> $past(rd_go) && $past(acq_run_out)
        && !acq_run_out) else $error("acquisition end without read");
    cover property (rd_go ##1 pod_oe_out);
    cover property ($rose(pod_attached_out));
    cover property ($rose(acq_end_out));
endmodule : sigmod_top_properties

bind sigmod_top sigmod_top_properties #(.WINDOW_CYC(WINDOW_CYC)) sigmod_top_properties_i (
    .clk_in, .rst_b_in, .pod_wr_in, .pod_op_in, .pod_data_out, .pod_oe_out, .pod_attached_out,
    .start_edge_in, .clk_edge_in, .grounded_in, .acq_run_out, .acq_end_out);

// >>> sigmod_host.sv
`timescale 1ns/1ps
`include "sigmod_defs.svh"
module sigmod_host (
    input wire logic clk_in,
    input wire sigmod_pkg::sigmod_byte_t pod_data_in,
    input wire logic pod_oe_in,
    output logic pod_wr_out,
    output sigmod_pkg::sigmod_byte_t pod_op_out
);
    import sigmod_pkg::*;
    initial begin
        pod_wr_out = 1'b0;
        pod_op_out = 8'h00;
    end
    // quiet cycle after each strobe; released byte inverted so it is never reused
    task automatic send_op(input logic [15:0] word);
        pod_wr_out <= 1'b1;
        pod_op_out <= word[7:0];
        @(posedge clk_in);
        pod_wr_out <= 1'b0;
        pod_op_out <= ~word[7:0];
        @(posedge clk_in);
    endtask : send_op
    task automatic read_byte(output sigmod_byte_t b, output logic oe);
        send_op({8'h00, `SM_OP_READ});
        @(negedge clk_in);
        b = pod_data_in;
        oe = pod_oe_in;
        @(posedge clk_in);
    endtask : read_byte
    task automatic get_result(input int n, output logic [63:0] w);
        sigmod_byte_t b;
        logic oe;
        w = 64'h0;
        send_op({8'h00, `SM_OP_DISARM});
        send_op({8'h00, `SM_OP_CLR_GATE});
        for (int i = 0; i < n; i++) begin
            read_byte(b, oe);
            w = {w[59:0], b[3:0]};
            send_op({8'h00, `SM_OP_SHIFT});
        end
    endtask : get_result
endmodule : sigmod_host

// >>> sigmod_top_tb_top.sv
`timescale 1ns/1ps
`include "sigmod_defs.svh"
module sigmod_top_tb_top;
    import sigmod_pkg::*;
    localparam int unsigned WIN = 40;
    logic clk_in, rst_b_in, start_edge_in, stop_edge_in, clk_edge_in, grounded_in, result_load_in;
    logic [103:0] result_data_in;
    logic pod_wr_in, pod_oe_out, pod_attached_out, acq_run_out, acq_end_out, oe, saw_end;
    sigmod_byte_t pod_op_in, pod_data_out, b;
    logic [31:0] awaddr_in, wdata_in, araddr_in, rdata_out, d;
    logic [3:0] wstrb_in;
    logic awvalid_in, awready_out, wvalid_in, wready_out, bvalid_out, bready_in;
    logic arvalid_in, arready_out, rvalid_out, rready_in;
    logic [1:0] bresp_out, rresp_out, r;
    logic [63:0] w;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    sigmod_top #(.WINDOW_CYC(WIN)) sigmod_top_i (.clk_in, .rst_b_in, .pod_wr_in, .pod_op_in,
        .pod_data_out, .pod_oe_out, .pod_attached_out, .start_edge_in, .stop_edge_in,
        .clk_edge_in, .grounded_in, .result_load_in, .result_data_in, .acq_run_out,
        .acq_end_out, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in, .wvalid_in,
        .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
        .rdata_out, .rresp_out, .rvalid_out, .rready_in);
    sigmod_host sigmod_host_i (.clk_in, .pod_data_in(pod_data_out), .pod_oe_in(pod_oe_out),
        .pod_wr_out(pod_wr_in), .pod_op_out(pod_op_in));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    function automatic logic [3:0] nib(input int g);
        return 4'(g * 3 + 1);
    endfunction : nib
    function automatic logic [63:0] span(input int first, input int last);
        logic [63:0] v;
        v = 64'h0;
        for (int g = first; g <= last; g++) v = {v[59:0], nib(g)};
        return v;
    endfunction : span
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic axi_write(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] resp);
        logic pa, pw, ha, hw;
        awaddr_in <= a;
        wdata_in <= dat;
        wstrb_in <= 4'hf;
        {awvalid_in, wvalid_in, bready_in} <= 3'h7;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk_in);
            ha = pa && awready_out === 1'b1;
            hw = pw && wready_out === 1'b1;
            @(posedge clk_in);
            if (ha) awvalid_in <= 1'b0;
            if (hw) wvalid_in <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        do @(negedge clk_in); while (bvalid_out !== 1'b1);
        resp = bresp_out;
        @(posedge clk_in);
        bready_in <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] resp);
        araddr_in <= a;
        {arvalid_in, rready_in} <= 2'h3;
        do @(negedge clk_in); while (arready_out !== 1'b1);
        @(posedge clk_in);
        arvalid_in <= 1'b0;
        do @(negedge clk_in); while (rvalid_out !== 1'b1);
        dat = rdata_out;
        resp = rresp_out;
        @(posedge clk_in);
        rready_in <= 1'b0;
    endtask : axi_read
    // order: load, clock, start, stop
    task automatic pulse(input logic [3:0] sel);
        {result_load_in, clk_edge_in, start_edge_in, stop_edge_in} <= sel;
        @(posedge clk_in);
        {result_load_in, clk_edge_in, start_edge_in, stop_edge_in} <= 4'h0;
        @(posedge clk_in);
    endtask : pulse
    // the end pulse lasts one cycle, shorter than a host read, so it is latched here
    always @(posedge clk_in) begin
        if (acq_end_out === 1'b1) saw_end <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        rst_b_in = 1'b0;
        saw_end = 1'b0;
        grounded_in = 1'b1;
        {result_load_in, clk_edge_in, start_edge_in, stop_edge_in} = 4'h0;
        {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h0;
        {awaddr_in, wdata_in, araddr_in} = 96'h0;
        wstrb_in = 4'h0;
        for (int g = 0; g < `SM_STAGES; g++) result_data_in[4 * g +: 4] = nib(g);
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        check({pod_attached_out, pod_oe_out}, 2'b00);
        sigmod_host_i.send_op({8'h00, `SM_OP_ATTACH});
        check(pod_attached_out, 1'b0);
        axi_read(`SM_REG_CTRL, d, r);
        check({r, d}, {`SM_RESP_OKAY, `SM_CTRL_RESET});
        axi_write(`SM_REG_CTRL, `SM_CTRL_RESET, r);
        check(r, `SM_RESP_OKAY);
        axi_read(32'h0000_0040, d, r);
        check({r, d}, {`SM_RESP_SLVERR, 32'h0});
        repeat (WIN + 5) @(posedge clk_in);
        sigmod_host_i.send_op({8'h00, `SM_OP_ATTACH});
        check(pod_attached_out, 1'b1);
        axi_read(`SM_REG_STATUS, d, r);
        check(d[`SM_ST_ATTACHED], 1'b1);
        pulse(4'hc);
        sigmod_host_i.send_op({8'h00, `SM_OP_ARM});
        pulse(4'h2);
        sigmod_host_i.read_byte(b, oe);
        check({oe, b}, {1'b1, 4'hb, nib(0)});
        sigmod_host_i.read_byte(b, oe);
        check({acq_run_out, b[3:0]}, {1'b1, nib(0)});
        sigmod_host_i.send_op({8'h00, `SM_OP_DISARM});
        sigmod_host_i.read_byte(b, oe);
        check({saw_end, acq_run_out}, 2'b10);
        sigmod_host_i.send_op({8'h00, `SM_OP_CLR_GATE});
        sigmod_host_i.send_op({8'h00, `SM_OP_ARM});
        pulse(4'h2);
        pulse(4'h1);
        sigmod_host_i.read_byte(b, oe);
        check(b[6:5], 2'b11);
        grounded_in <= 1'b0;
        repeat (WIN + 5) @(posedge clk_in);
        sigmod_host_i.read_byte(b, oe);
        check({b[7], b[4]}, 2'b00);
        sigmod_host_i.get_result(4, w);
        check(w, span(0, 3));
        sigmod_host_i.get_result(6, w);
        check(w, span(4, 9));
        sigmod_host_i.get_result(16, w);
        check(w, span(10, 25));
        sigmod_host_i.read_byte(b, oe);
        check(b[3:0], 4'h0);
        sigmod_host_i.send_op({8'h00, `SM_OP_DETACH});
        check(pod_attached_out, 1'b0);
        tally_and_finish();
    end
endmodule : sigmod_top_tb_top
